/* inc/sfc_defs.svh */
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// status register bit positions
`define SFC_BIT_C 3'd0
`define SFC_BIT_Z 3'd1
`define SFC_BIT_N 3'd2
`define SFC_BIT_V 3'd3
`define SFC_BIT_S 3'd4
`define SFC_BIT_H 3'd5
`define SFC_BIT_T 3'd6
`define SFC_BIT_I 3'd7

// reset value of the status register
`define SFC_STATUS_REGISTER_RST 8'h00

// cycles taken by every fixed-length operation
`define SFC_OP_CYCLES 1

`endif

/* inc/sfc_pkg.sv */
package sfc_pkg;

  typedef enum logic [4:0] {
    SFC_OP_NONE,
    SFC_OP_SIGN_SET,
    SFC_OP_SIGN_CLR,
    SFC_OP_OVF_SET,
    SFC_OP_OVF_CLR,
    SFC_OP_HALF_CLR,
    SFC_OP_NEG_SET,
    SFC_OP_NEG_CLR,
    SFC_OP_ZERO_SET,
    SFC_OP_ZERO_CLR,
    SFC_OP_XFER_SET,
    SFC_OP_XFER_CLR,
    SFC_OP_IRQ_ON,
    SFC_OP_IRQ_OFF,
    SFC_OP_IDLE,
    SFC_OP_SLEEP,
    SFC_OP_WDOG_KICK,
    SFC_OP_DEBUG_HALT
  } sfc_op_e;

  typedef enum logic [1:0] {
    SFC_ST_RUN,
    SFC_ST_HALT
  } sfc_state_e;

  // one decoded operation: which flag, what value, side effects
  typedef struct packed {
    logic       flag_we;
    logic [2:0] flag_idx;
    logic       flag_val;
    logic       sleep;
    logic       wdog;
    logic       halt;
  } sfc_dec_s;

  typedef struct packed {
    logic       valid;
    sfc_op_e    op;
  } sfc_req_s;

  typedef struct packed {
    logic       done;
    logic       sleep_req;
    logic       wdog_kick;
    logic       debug_halt;
  } sfc_evt_s;

endpackage : sfc_pkg

/* rtl/sfc_flag_bit.sv */
`include "sfc_defs.svh"

// one status flag: load from the core, or single-bit write from this block
module sfc_flag_bit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic rst_val,
  input wire logic core_we,
  input wire logic core_val,
  input wire logic op_we,
  input wire logic op_val,
  output logic flag
);
  import sfc_pkg::*;

  typedef struct packed {
    logic flag;
  } sfc_fb_s;

  sfc_fb_s st_ff;
  sfc_fb_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // the flag instruction is the newer write, so it wins over a core load
    if (op_we) begin
      nxt_st.flag = op_val;
    end else if (core_we) begin
      nxt_st.flag = core_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff.flag <= rst_val;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;

endmodule : sfc_flag_bit

/* rtl/sfc_status_ctrl.sv */
// Summary of operation
// - sign-flag set writes S to one in one cycle, only S changes
// - sign-flag clear writes S to zero in one cycle
// - overflow set writes V to one in one cycle, others untouched
// - overflow clear writes V to zero in one cycle, others untouched
// - half-carry clear writes H to zero in one cycle, only H changes
// - sleep takes one cycle, no flag change, pulses the sleep request
// - watchdog kick takes one cycle, no flag change, pulses the watchdog
// - debug halt only for on-chip debug, no flags, no fixed cycle count
`include "sfc_defs.svh"

module sfc_status_ctrl #(
  parameter int STATUS_REGISTER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire sfc_pkg::sfc_req_s req,
  output logic req_ready,
  input wire logic core_we,
  input wire logic [STATUS_REGISTER_W-1:0] core_mask,
  input wire logic [STATUS_REGISTER_W-1:0] core_data,
  input wire logic debug_resume,
  output logic [STATUS_REGISTER_W-1:0] status_register,
  output sfc_pkg::sfc_evt_s evt
);
  import sfc_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic sfc_dec_s decode(input sfc_op_e op);
    sfc_dec_s d;
    d = '0;
    case (op)
      SFC_OP_SIGN_SET: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_S;
        d.flag_val = 1'b1;
      end
      SFC_OP_SIGN_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_S;
        d.flag_val = 1'b0;
      end
      SFC_OP_OVF_SET: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_V;
        d.flag_val = 1'b1;
      end
      SFC_OP_OVF_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_V;
        d.flag_val = 1'b0;
      end
      SFC_OP_HALF_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_H;
        d.flag_val = 1'b0;
      end
      SFC_OP_NEG_SET: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_N;
        d.flag_val = 1'b1;
      end
      SFC_OP_NEG_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_N;
        d.flag_val = 1'b0;
      end
      SFC_OP_ZERO_SET: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_Z;
        d.flag_val = 1'b1;
      end
      SFC_OP_ZERO_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_Z;
        d.flag_val = 1'b0;
      end
      SFC_OP_XFER_SET: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_T;
        d.flag_val = 1'b1;
      end
      SFC_OP_XFER_CLR: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_T;
        d.flag_val = 1'b0;
      end
      SFC_OP_IRQ_ON: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_I;
        d.flag_val = 1'b1;
      end
      SFC_OP_IRQ_OFF: begin
        d.flag_we = 1'b1;
        d.flag_idx = `SFC_BIT_I;
        d.flag_val = 1'b0;
      end
      SFC_OP_IDLE: begin
        // retires with no side effect at all
        d = '0;
      end
      SFC_OP_SLEEP: begin
        d.sleep = 1'b1;
      end
      SFC_OP_WDOG_KICK: begin
        d.wdog = 1'b1;
      end
      SFC_OP_DEBUG_HALT: begin
        d.halt = 1'b1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction : decode

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sfc_state_e state;
    sfc_evt_s evt;
  } sfc_top_s;

  sfc_top_s st_ff;
  sfc_top_s nxt_st;
  sfc_dec_s dec;
  logic take;

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  // halted core accepts nothing until the debugger resumes it
  // ready is a plain decode of state, so it drops in the cycle halt is entered
  assign req_ready = (st_ff.state == SFC_ST_RUN);
  assign take = req.valid && req_ready && ce;
  assign dec = take ? decode(req.op) : '0;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.evt = '0;
    case (st_ff.state)
      SFC_ST_RUN: begin
        if (take) begin
          // every fixed-length operation retires in one cycle
          nxt_st.evt.done = !dec.halt;
          nxt_st.evt.sleep_req = dec.sleep;
          nxt_st.evt.wdog_kick = dec.wdog;
          if (dec.halt) begin
            nxt_st.state = SFC_ST_HALT;
            nxt_st.evt.debug_halt = 1'b1;
          end
        end
      end
      SFC_ST_HALT: begin
        // duration set by the debugger, not by this block
        if (debug_resume) begin
          nxt_st.state = SFC_ST_RUN;
          nxt_st.evt.done = 1'b1;
        end
      end
      default: nxt_st.state = SFC_ST_RUN;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // ce low holds every bit, pending pulses included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff.state <= SFC_ST_RUN;
      st_ff.evt <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // event outputs
  // ----------------------------------------
  // registered so the sleep and watchdog units see clean one-cycle pulses
  assign evt = st_ff.evt;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  localparam logic [STATUS_REGISTER_W-1:0] STATUS_REGISTER_RST = STATUS_REGISTER_W'(`SFC_STATUS_REGISTER_RST);

  // one-hot flag write select while STATUS_REGISTER_W is 8 or less; an index past STATUS_REGISTER_W selects nothing
  function automatic logic [STATUS_REGISTER_W-1:0] flag_sel(input sfc_dec_s d);
    logic [STATUS_REGISTER_W-1:0] m;
    m = '0;
    for (int k = 0; k < STATUS_REGISTER_W; k++) begin
      if (d.flag_we && (d.flag_idx == 3'(k))) begin
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : flag_sel

  logic [STATUS_REGISTER_W-1:0] op_sel;
  logic [STATUS_REGISTER_W-1:0] core_sel;

  // at most one bit set while STATUS_REGISTER_W is 8 or less, so a flag op never spills into a neighbour
  assign op_sel = flag_sel(dec);
  assign core_sel = core_we ? core_mask : '0;

  for (genvar i = 0; i < STATUS_REGISTER_W; i++) begin : g_flag
    sfc_flag_bit u_flag (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .rst_val(STATUS_REGISTER_RST[i]),
      .core_we(core_sel[i]),
      .core_val(core_data[i]),
      .op_we(op_sel[i]),
      .op_val(dec.flag_val),
      .flag(status_register[i])
    );
  end

endmodule : sfc_status_ctrl

/* verif/sfc_chk.sv */
// ----
// flag and control op checks
// ----
module sfc_chk
  import sfc_pkg::*;
#(
  parameter int STATUS_REGISTER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire sfc_pkg::sfc_req_s req,
  input wire logic req_ready,
  input wire logic core_we,
  input wire logic [STATUS_REGISTER_W-1:0] core_mask,
  input wire logic [STATUS_REGISTER_W-1:0] core_data,
  input wire logic debug_resume,
  input wire logic [STATUS_REGISTER_W-1:0] status_register,
  input wire sfc_pkg::sfc_evt_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // q excludes core loads, which may move other flags in the same cycle
  wire tk = req.valid & req_ready & ce;
  wire q = tk & !core_we;
  sequence s_halt;
    q && req.op == SFC_OP_DEBUG_HALT ##1 evt.debug_halt;
  endsequence
  a_sign_set:
    assert property (tk && req.op == SFC_OP_SIGN_SET |=> status_register[4] && evt.done) else $error("s set");
  a_sign_clr:
    assert property (tk && req.op == SFC_OP_SIGN_CLR |=> !status_register[4]) else $error("s clr");
  a_ovf_only:
    assert property (q && req.op == SFC_OP_OVF_SET |=> status_register == ($past(status_register) | 8'h08))
      else $error("v set");
  a_half_only:
    assert property (q && req.op == SFC_OP_HALF_CLR |=> status_register == ($past(status_register) & 8'hDF))
      else $error("h clr");
  a_sleep_pulse:
    assert property (q && req.op == SFC_OP_SLEEP |=> evt.sleep_req && $stable(status_register)) else $error("sleep");
  a_wdog_pulse:
    assert property (q && req.op == SFC_OP_WDOG_KICK |=> evt.wdog_kick && $stable(status_register)) else $error("wdog");
  a_halt_entry:
    assert property (s_halt |-> !req_ready && $stable(status_register)) else $error("halt");
  a_irq_on:
    assert property (tk && req.op == SFC_OP_IRQ_ON |=> status_register[7]) else $error("irq on");
endmodule : sfc_chk

bind sfc_status_ctrl sfc_chk #(.STATUS_REGISTER_W(STATUS_REGISTER_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req),
  .req_ready(req_ready), .core_we(core_we), .core_mask(core_mask), .core_data(core_data),
  .debug_resume(debug_resume), .status_register(status_register), .evt(evt));

/* verif/sfc_status_ctrl_tb.sv */
// ----
// bench
// ----
module sfc_status_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfc_pkg::*;
  logic clk_sys = 0, rst = 1, ce = 1, core_we = 0, debug_resume = 0, req_ready;
  logic [7:0] core_mask = 8'h00, core_data = 8'h00, status_register;
  sfc_req_s req = '0;
  sfc_evt_s evt;
  int mismatches = 0, n_compared = 0;
  sfc_status_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .req(req), .req_ready(req_ready),
    .core_we(core_we), .core_mask(core_mask), .core_data(core_data), .debug_resume(debug_resume),
    .status_register(status_register), .evt(evt));
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task conclude;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // set/clear ops back to back; each clear follows its set so it shows, except H, which the core load presets before its clear
  task automatic t_flags;
    logic [7:0] e = 8'h20;
    int b[13] = '{4, 4, 3, 3, 5, 2, 2, 1, 1, 6, 6, 7, 7};
    logic v[13] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    @(negedge clk_sys);
    {core_we, core_mask, core_data} = {1'b1, 8'hFF, e};
    @(negedge clk_sys);
    core_we = 0;
    for (int i = 1; i <= 13; i++) begin
      req = '{1'b1, sfc_op_e'(i)};
      e[b[i-1]] = v[i-1];
      @(negedge clk_sys);
      chk("flags", status_register, e);
      chk("evt", {4'h0, evt}, 8'h08);
    end
    req.valid = 0;
  endtask : t_flags
  task automatic t_ctrl;
    logic [7:0] s;
    logic [7:0] ev[3] = '{8'h08, 8'h0C, 8'h0A};
    @(negedge clk_sys);
    s = status_register;
    for (int i = 0; i < 3; i++) begin
      req = '{1'b1, sfc_op_e'(14 + i)};
      @(negedge clk_sys);
      chk("evt", {4'h0, evt}, ev[i]);
      chk("flags", status_register, s);
    end
    req.valid = 0;
    @(negedge clk_sys);
    chk("evt", {4'h0, evt}, 8'h00);
  endtask : t_ctrl
  task automatic t_halt;
    logic [7:0] s;
    @(negedge clk_sys);
    s = status_register;
    req = '{1'b1, SFC_OP_DEBUG_HALT};
    @(negedge clk_sys);
    chk("evt", {4'h0, evt}, 8'h01);
    chk("ready", {7'h00, req_ready}, 8'h00);
    req = '{1'b1, SFC_OP_SIGN_SET};
    repeat (3) @(negedge clk_sys);
    chk("flags", status_register, s);
    req.valid = 0;
    debug_resume = 1;
    @(negedge clk_sys);
    debug_resume = 0;
    chk("evt", {4'h0, evt}, 8'h08);
    chk("ready", {7'h00, req_ready}, 8'h01);
  endtask : t_halt
  // ce low freezes everything; then a flag op and a core load share a cycle
  task automatic t_ce;
    logic [7:0] s;
    @(negedge clk_sys);
    s = status_register;
    {ce, core_we, core_mask, core_data} = {1'b0, 1'b1, 8'hFF, 8'hFF};
    req = '{1'b1, SFC_OP_SLEEP};
    repeat (2) @(negedge clk_sys);
    chk("ce flags", status_register, s);
    chk("ce evt", {4'h0, evt}, 8'h00);
    {ce, core_we} = 2'b10;
    @(negedge clk_sys);
    chk("sleep evt", {4'h0, evt}, 8'h0C);
    {core_we, core_mask, core_data} = {1'b1, 8'h11, 8'h01};
    req = '{1'b1, SFC_OP_SIGN_SET};
    @(negedge clk_sys);
    {req.valid, core_we} = 2'b00;
    chk("op beats load", status_register, s | 8'h11);
    chk("op evt", {4'h0, evt}, 8'h08);
  endtask : t_ce
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    chk("reset", status_register, 8'h00);
    t_flags();
    t_ctrl();
    t_halt();
    t_ce();
    conclude();
  end
  // whole run is under 50 cycles past reset
  initial begin
    repeat (500) @(posedge clk_sys);
    mismatches++;
    conclude();
  end
endmodule : sfc_status_ctrl_tb
